// File: logic/ivp_core.sv
// Purpose: interrupt vector table and priority resolution with an AXI4-Lite register port
// Assumes: request pins are asynchronous; core ack, fetch and break come from ref_clk logic
// Notes:   pending bits clear only on core ack; a new request in that cycle still wins
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ivp_core
    import ivp_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // axi4-lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // peripheral request pins
    input  wire ivp_req_t    req_pins,
    // core side
    input  wire logic        software_break_instruction,
    input  wire logic        core_ack,
    input  wire logic        core_fetch_en,
    input  wire logic [15:0] core_fetch_addr,
    output ivp_vec_t         core_vec,
    output logic [7:0]       core_fetch_data,
    // system interrupt
    output logic             irq
);

    // request synchronisers and edge detect
    logic [NUM_SRC-1:0] sync1_r;   // first stage, read only by sync2_r
    logic [NUM_SRC-1:0] sync2_r;   // second stage, safe to use
    logic [NUM_SRC-1:0] sync3_r;   // previous safe value for edge detect
    logic               brk_prev_r; // break strobe history

    // three-stage shift; only the last two feed logic
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1_r    <= '0;
            sync2_r    <= '0;
            sync3_r    <= '0;
            brk_prev_r <= 1'b0;
        end else begin
            sync1_r    <= req_pins;
            sync2_r    <= sync1_r;
            sync3_r    <= sync2_r;
            brk_prev_r <= software_break_instruction;
        end
    end

    wire ivp_req_t rise     = ivp_req_t'(sync2_r & ~sync3_r); // one-cycle request events
    wire logic     brk_rise = software_break_instruction & ~brk_prev_r;

    // register state
    logic [7:0]         src_set_r;   // source-set register
    logic [7:0]         src_disc_r;  // source-discrimination register
    logic [NUM_VEC-1:0] pend_r;      // vectors waiting for the core
    logic [NUM_VEC-1:0] stat_r;      // serviced-vector sticky status
    logic [NUM_VEC-1:0] mask_r;      // status mask onto irq
    logic [15:0]        vtab_r [NUM_VEC]; // handler addresses

    // shared vector gating
    wire logic wake_ev = rise.key_wakeup    & src_set_r[SRC_WAKE_BIT];
    wire logic coll_ev = rise.bus_collision & src_set_r[SRC_COLL_BIT];
    wire logic conv_ev = rise.conv_done     & src_set_r[SRC_CONV_BIT];
    wire logic t1_ev   = rise.timer_1       & src_set_r[SRC_T1_BIT];

    // vector set terms in priority order
    wire logic [NUM_VEC-1:0] pend_set = {
        brk_rise,                              // 17 software break
        conv_ev | t1_ev,                       // 16 converter / timer 1
        rise.timer_b,                          // 15
        rise.timer_a,                          // 14
        rise.timer_x,                          // 13
        rise.compare,                          // 12
        rise.capture_chan_b,                   // 11
        rise.capture_chan_a,                   // 10
        rise.counter_pin_a,                    // 9
        wake_ev | coll_ev,                     // 8 wake-up / bus collision
        rise.ext_pin_irq_b,                    // 7
        rise.ext_pin_irq_a,                    // 6
        rise.sio2_tx,                          // 5
        rise.sio2_rx,                          // 4
        rise.sio1_tx,                          // 3
        rise.sio1_rx,                          // 2
        1'b0                                   // 1 reset, set only by sys_rst
    };

    // core acknowledge
    wire logic               ack_take = core_ack & core_vec.valid;
    wire logic [NUM_VEC-1:0] ack_clr  = ack_take ? (NUM_VEC'(1) << core_vec.idx) : '0;
    // set wins over the ack clear
    wire logic [NUM_VEC-1:0] pend_nxt = (pend_r & ~ack_clr) | pend_set;

    // winner is taken from the next pending value so outputs track an ack at once
    logic       pick_found;
    logic [4:0] pick_idx;

    ivp_prio_pick u_pick (
        .pend    (pend_nxt),
        .found   (pick_found),
        .win_idx (pick_idx)
    );

    // axi write channel
    logic        aw_have_r;  // write address held
    logic [11:0] aw_addr_r;  // held write address
    logic        w_have_r;   // write data held
    logic [31:0] w_data_r;   // held write data
    logic [3:0]  w_strb_r;   // held byte strobes

    wire logic aw_take = s_axi_awvalid & s_axi_awready;
    wire logic w_take  = s_axi_wvalid & s_axi_wready;
    wire logic wr_do   = aw_have_r & w_have_r & ~s_axi_bvalid;
    wire logic b_nxt   = (s_axi_bvalid & ~s_axi_bready) | wr_do;
    wire logic aw_nxt  = (aw_have_r & ~wr_do) | aw_take;
    wire logic w_nxt   = (w_have_r & ~wr_do) | w_take;

    // merge written bytes into an old word
    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        for (int b = 0; b < 4; b++) begin
            old_v[b*8 +: 8] = strb[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
        end
        strb_merge = old_v;
    endfunction

    // handler table decode: one word per vector from ADDR_VTAB
    function automatic logic vtab_hit(input logic [11:0] a);
        vtab_hit = (a[11:7] == ADDR_VTAB[11:7]) && (a[6:2] < 5'(NUM_VEC)) && (a[1:0] == 2'h0);
    endfunction

    // write decode
    wire logic        wr_set   = wr_do && (aw_addr_r == ADDR_SRC_SET);
    wire logic        wr_disc  = wr_do && (aw_addr_r == ADDR_SRC_DISC);
    wire logic        wr_stat  = wr_do && (aw_addr_r == ADDR_STATUS);
    wire logic        wr_mask  = wr_do && (aw_addr_r == ADDR_MASK);
    wire logic        wr_pend  = wr_do && (aw_addr_r == ADDR_PENDING);
    wire logic        wr_vtab  = wr_do && vtab_hit(aw_addr_r);
    wire logic [4:0]  wr_vidx  = aw_addr_r[6:2];
    wire logic        wr_known = wr_set | wr_disc | wr_stat | wr_mask | wr_pend | wr_vtab;
    wire logic [31:0] w_merged_set  = strb_merge({24'h0, src_set_r}, w_data_r, w_strb_r);
    wire logic [31:0] w_merged_mask = strb_merge({15'h0, mask_r}, w_data_r, w_strb_r);
    wire logic [31:0] w_stat_ones   = strb_merge(32'h0, w_data_r, w_strb_r);
    wire logic [31:0] w_merged_vtab = strb_merge({16'h0, vtab_r[wr_vidx]}, w_data_r, w_strb_r);

    // write handshake state
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            aw_have_r     <= 1'b0;
            aw_addr_r     <= 12'h000;
            w_have_r      <= 1'b0;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            aw_have_r     <= aw_nxt;
            w_have_r      <= w_nxt;
            s_axi_awready <= ~aw_nxt & ~b_nxt;
            s_axi_wready  <= ~w_nxt & ~b_nxt;
            s_axi_bvalid  <= b_nxt;
            // capture address and data as they are taken
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            // unmapped addresses answer slave error
            if (wr_do) begin
                s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // axi read channel
    wire logic ar_take = s_axi_arvalid & s_axi_arready;
    wire logic r_nxt   = (s_axi_rvalid & ~s_axi_rready) | ar_take;

    wire logic        rd_set   = (s_axi_araddr == ADDR_SRC_SET);
    wire logic        rd_disc  = (s_axi_araddr == ADDR_SRC_DISC);
    wire logic        rd_stat  = (s_axi_araddr == ADDR_STATUS);
    wire logic        rd_mask  = (s_axi_araddr == ADDR_MASK);
    wire logic        rd_pend  = (s_axi_araddr == ADDR_PENDING);
    wire logic        rd_vtab  = vtab_hit(s_axi_araddr);
    wire logic        rd_known = rd_set | rd_disc | rd_stat | rd_mask | rd_pend | rd_vtab;
    wire logic [31:0] rd_word  =
        rd_set  ? {24'h0, src_set_r}  :
        rd_disc ? {24'h0, src_disc_r} :
        rd_stat ? {15'h0, stat_r}     :
        rd_mask ? {15'h0, mask_r}     :
        rd_pend ? {15'h0, pend_r}     :
        rd_vtab ? {16'h0, vtab_r[s_axi_araddr[6:2]]} : 32'h0000_0000;

    // read handshake state; reading the discrimination register clears it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~r_nxt;
            s_axi_rvalid  <= r_nxt;
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // source discrimination
    wire logic [7:0] disc_set = {4'h0, t1_ev, conv_ev, coll_ev, wake_ev};
    wire logic       disc_clr = ar_take & rd_disc;
    // a new occurrence in the clearing read cycle is kept
    wire logic [7:0] disc_nxt = (disc_clr ? 8'h00 : src_disc_r) | disc_set;

    // status / mask
    // write one clears; a service in the same cycle sets again
    wire logic [NUM_VEC-1:0] stat_nxt =
        (stat_r & ~(wr_stat ? w_stat_ones[NUM_VEC-1:0] : '0)) | ack_clr;

    // control registers, pending, status and handler table
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            src_set_r  <= SRC_SET_RST;
            src_disc_r <= SRC_DISC_RST;
            pend_r     <= PEND_RST;
            stat_r     <= STATUS_RST;
            mask_r     <= MASK_RST;
            for (int v = 0; v < NUM_VEC; v++) begin
                vtab_r[v] <= VTAB_RST;
            end
        end else begin
            pend_r     <= pend_nxt;
            stat_r     <= stat_nxt;
            src_disc_r <= disc_nxt;
            // source enables steer the shared vectors
            if (wr_set) begin
                src_set_r <= w_merged_set[7:0];
            end
            if (wr_mask) begin
                mask_r <= w_merged_mask[NUM_VEC-1:0];
            end
            // low byte in bits 7:0, high byte in bits 15:8
            if (wr_vtab) begin
                vtab_r[wr_vidx] <= w_merged_vtab[15:0];
            end
        end
    end

    // core vector offer and fetch
    wire logic [15:0] fetch_off = core_fetch_addr - VEC_BASE_LO;
    wire logic        fetch_in  = (core_fetch_addr >= VEC_BASE_LO) &&
                                  (core_fetch_addr <= VEC_RESET_HI);
    // off 0 is the break low byte; index counts up from the top of the table
    wire logic [4:0]  fetch_idx = 5'(IDX_BREAK - fetch_off[5:1]);
    wire logic [15:0] fetch_w   = vtab_r[fetch_idx];
    // odd (upper) address returns the high byte
    wire logic [7:0]  fetch_b   = fetch_off[0] ? fetch_w[15:8] : fetch_w[7:0];

    // registered vector offer, fetch data and system irq
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            core_vec        <= '{valid: 1'b0, idx: IDX_RESET, lo_addr: VEC_RESET_LO};
            core_fetch_data <= 8'h00;
            irq             <= 1'b0;
        end else begin
            core_vec.valid   <= pick_found;
            core_vec.idx     <= pick_idx;
            core_vec.lo_addr <= vec_lo_addr(pick_idx);
            if (core_fetch_en) begin
                core_fetch_data <= fetch_in ? fetch_b : 8'h00;
            end
            irq <= |(stat_nxt & mask_r);
        end
    end

endmodule

// File: inc/ivp_pkg.sv
// Purpose: shared constants and carriers for the interrupt vector and priority block
// Assumes: 12-bit AXI4-Lite byte address, 32-bit data, one aligned word per register
// Notes:   vector index n has priority n+1 and its low byte sits at 16'hFFFC - 2*n
package ivp_pkg;

    // vector table geometry
    localparam int          NUM_VEC       = 17;        // reset plus sixteen request vectors
    localparam int          NUM_SRC       = 17;        // request lines arriving from peripherals
    localparam logic [15:0] VEC_RESET_LO  = 16'hFFFC;  // reset vector, low byte
    localparam logic [15:0] VEC_RESET_HI  = 16'hFFFD;  // reset vector, high byte
    localparam logic [15:0] VEC_BASE_LO   = 16'hFFDC;  // lowest vector byte (software break)
    localparam logic [15:0] VEC_WAKE_LO   = 16'hFFEE;  // shared wake-up / bus collision
    localparam logic [15:0] VEC_CONV_LO   = 16'hFFDE;  // shared converter / timer 1

    // vector indices (priority number minus one)
    localparam logic [4:0]  IDX_RESET     = 5'h00;     // priority 1
    localparam logic [4:0]  IDX_WAKE      = 5'h07;     // priority 8
    localparam logic [4:0]  IDX_CONV      = 5'h0F;     // priority 16
    localparam logic [4:0]  IDX_BREAK     = 5'h10;     // priority 17

    // printed register indices; byte address is four times the index
    localparam logic [11:0] REG_IDX_SRC_SET  = 12'h00A;
    localparam logic [11:0] REG_IDX_SRC_DISC = 12'h00B;
    localparam logic [11:0] ADDR_SRC_SET     = REG_IDX_SRC_SET << 2;
    localparam logic [11:0] ADDR_SRC_DISC    = REG_IDX_SRC_DISC << 2;
    localparam logic [11:0] ADDR_STATUS      = 12'h040;   // serviced-vector sticky bits
    localparam logic [11:0] ADDR_MASK        = 12'h044;   // interrupt mask
    localparam logic [11:0] ADDR_PENDING     = 12'h048;   // live pending vectors
    localparam logic [11:0] ADDR_VTAB        = 12'h100;   // handler table, one word per vector

    // field positions inside the source-set and source-discrimination registers
    localparam int          SRC_WAKE_BIT  = 0;
    localparam int          SRC_COLL_BIT  = 1;
    localparam int          SRC_CONV_BIT  = 2;
    localparam int          SRC_T1_BIT    = 3;

    // reset values
    localparam logic [7:0]  SRC_SET_RST   = 8'h00;
    localparam logic [7:0]  SRC_DISC_RST  = 8'h00;
    localparam logic [16:0] MASK_RST      = 17'h00000;
    localparam logic [16:0] STATUS_RST    = 17'h00000;
    localparam logic [16:0] PEND_RST      = 17'h00001;    // reset vector pending out of reset
    localparam logic [15:0] VTAB_RST      = 16'h0000;

    // bus answers
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // peripheral request lines, lsb first in priority order after reset
    typedef struct packed {
        logic timer_1;
        logic conv_done;
        logic timer_b;
        logic timer_a;
        logic timer_x;
        logic compare;
        logic capture_chan_b;
        logic capture_chan_a;
        logic counter_pin_a;
        logic bus_collision;
        logic key_wakeup;
        logic ext_pin_irq_b;
        logic ext_pin_irq_a;
        logic sio2_tx;
        logic sio2_rx;
        logic sio1_tx;
        logic sio1_rx;
    } ivp_req_t;

    // vector offered to the core
    typedef struct packed {
        logic        valid;
        logic [4:0]  idx;
        logic [15:0] lo_addr;
    } ivp_vec_t;

    // low-byte address of a vector from its index
    function automatic logic [15:0] vec_lo_addr(input logic [4:0] idx);
        vec_lo_addr = VEC_RESET_LO - {10'h000, idx, 1'b0};
    endfunction

endpackage

// File: logic/ivp_prio_pick.sv
// Purpose: picks the pending vector with the smallest priority number
// Assumes: bit n of the pending vector is priority n+1
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps
module ivp_prio_pick
    import ivp_pkg::*;
(
    // pending vectors
    input  wire logic [NUM_VEC-1:0] pend,
    // winner
    output logic                    found,
    output logic [4:0]              win_idx
);

    // scan from the bottom of the table up so the lowest index is taken last and wins
    always_comb begin
        found   = 1'b0;
        win_idx = 5'h00;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                found   = 1'b1;
                win_idx = 5'(i);
            end
        end
    end

endmodule

// File: dv/ivp_core_sva.sv
// Purpose: port-level assertions for the vector and priority block
// Assumes: one ref_clk domain, sys_rst synchronous and active high
// Notes:   bound onto ivp_core below the module
`timescale 1ns/1ps
module ivp_core_sva
    import ivp_pkg::*;
(
    // clock and reset
    input wire logic     ref_clk,
    input wire logic     sys_rst,
    // register bus handshakes
    input wire logic     s_axi_awvalid,
    input wire logic     s_axi_awready,
    input wire logic     s_axi_wvalid,
    input wire logic     s_axi_wready,
    input wire logic     s_axi_bvalid,
    input wire logic     s_axi_arvalid,
    input wire logic     s_axi_arready,
    input wire logic     s_axi_rvalid,
    // core side
    input wire logic     software_break_instruction,
    input wire logic     core_ack,
    input wire ivp_vec_t core_vec
);
    // one domain, so clock and reset are given once
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_reset_idle: assert property ($fell(sys_rst) |-> !s_axi_bvalid && !core_vec.valid)
        else $error("outputs busy at reset release");
    a_reset_vector: assert property ($fell(sys_rst) |=> core_vec.valid &&
        core_vec.idx == IDX_RESET && core_vec.lo_addr == VEC_RESET_LO)
        else $error("reset vector not offered first");
    a_vec_address: assert property (core_vec.valid |-> core_vec.idx <= IDX_BREAK &&
        core_vec.lo_addr == 16'hFFFC - {10'h000, core_vec.idx, 1'b0})
        else $error("vector address does not match its rank");
    a_break_posted: assert property ($rose(software_break_instruction) |->
        ##2 core_vec.valid)
        else $error("break request not posted");
    a_rank_hold: assert property (core_vec.valid && !core_ack |=>
        core_vec.valid && core_vec.idx <= $past(core_vec.idx))
        else $error("offered vector lost rank without ack");
    a_reset_once: assert property (core_ack && core_vec.valid && core_vec.idx == IDX_RESET
        |=> !core_vec.valid || core_vec.idx != IDX_RESET)
        else $error("reset vector offered again after ack");
    a_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response open");
    a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
endmodule
bind ivp_core ivp_core_sva u_ivp_core_sva (.*);

// File: dv/ivp_core_model.sv
// Purpose: processor core that takes offered vectors and fetches handler addresses
// Assumes: ack and fetch follow the block's hand-over timing on ref_clk
// Notes:   alternates prompt and slow acks; records each serviced vector
`timescale 1ns/1ps
module ivp_core_model
    import ivp_pkg::*;
(
    // clock and control
    input wire logic      ref_clk,
    input wire logic      run_en,
    // block side
    input wire ivp_vec_t  core_vec,
    input wire logic[7:0] core_fetch_data,
    output logic          core_ack,
    output logic          core_fetch_en,
    output logic [15:0]   core_fetch_addr,
    // record of service
    output logic [4:0]    served_idx,
    output logic [15:0]   served_addr,
    output logic [7:0]    served_cnt
);
    // service loop: ack, then low byte, then high byte
    initial begin
        ivp_vec_t   v;
        logic [7:0] lo;
        core_ack = 1'b0;
        core_fetch_en = 1'b0;
        core_fetch_addr = 16'h0000;
        served_idx = 5'h00;
        served_addr = 16'h0000;
        served_cnt = 8'h00;
        forever begin
            @(posedge ref_clk);
            if (run_en && core_vec.valid) begin
                repeat (served_cnt[0] ? 2 : 0) @(posedge ref_clk);
                core_ack <= 1'b1;
                @(posedge ref_clk);
                v = core_vec;
                core_ack <= 1'b0;
                core_fetch_en <= 1'b1;
                core_fetch_addr <= v.lo_addr;
                @(posedge ref_clk);
                core_fetch_en <= 1'b0;
                core_fetch_addr <= ~v.lo_addr;
                @(posedge ref_clk);
                lo = core_fetch_data;
                core_fetch_en <= 1'b1;
                core_fetch_addr <= v.lo_addr + 16'h0001;
                @(posedge ref_clk);
                core_fetch_en <= 1'b0;
                core_fetch_addr <= ~v.lo_addr;
                @(posedge ref_clk);
                // high byte sits at the upper address
                served_addr <= {core_fetch_data, lo};
                served_idx <= v.idx;
                served_cnt <= served_cnt + 8'h01;
            end
        end
    end
endmodule

// File: dv/testbench.sv
// Purpose: self-checking bench for the vector and priority block
// Assumes: bready and rready held high; core model serves when run_en is set
// Notes:   handler for vector n is {C0+n, 10+n}
`timescale 1ns/1ps
module testbench
    import ivp_pkg::*;
;
    logic        ref_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, run_en;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        software_break_instruction, core_ack, core_fetch_en;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] core_fetch_addr, served_addr;
    logic [7:0]  core_fetch_data, served_cnt;
    logic [4:0]  served_idx;
    ivp_req_t    req_pins;
    ivp_vec_t    core_vec;
    int          err_count, cmp_count;

    ivp_core u_ivp_core (.*, .s_axi_wstrb(4'hF), .s_axi_bready(1'b1), .s_axi_rready(1'b1));
    ivp_core_model u_ivp_core_model (.*);

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // write one word, both channels offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge ref_clk);
            if (s_axi_awready && !aw_d) begin
                aw_d = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_d) begin
                w_d = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (!s_axi_bvalid);
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    // read one word and compare data and response
    task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(er));
    endtask

    // wait for the core model to finish one service
    task automatic serve(input logic [4:0] ei);
        logic [7:0] c;
        c = served_cnt;
        while (served_cnt == c) @(posedge ref_clk);
        chk(32'(served_idx), 32'(ei));
        chk(32'(served_addr), {16'h0, 8'hC0 + 8'(ei), 8'h10 + 8'(ei)});
    endtask

    // raise request pins long enough to pass the synchroniser
    task automatic pulse(input logic [16:0] p);
        req_pins <= p;
        repeat (8) @(posedge ref_clk);
        req_pins <= 17'h00000;
        @(posedge ref_clk);
    endtask

    task automatic t_reset();
        chk({10'h0, core_vec}, {10'h0, 1'b1, IDX_RESET, VEC_RESET_LO});
        rc(ADDR_PENDING, 32'h1, RESP_OKAY);
        rc(ADDR_SRC_SET, 32'h0, RESP_OKAY);
        rc(ADDR_SRC_DISC, 32'h0, RESP_OKAY);
        rc(ADDR_MASK, 32'h0, RESP_OKAY);
        rc(ADDR_STATUS, 32'h0, RESP_OKAY);
        rc(12'hFF0, 32'h0, RESP_SLVERR);
        wr(12'hFF0, 32'hFFFFFFFF, RESP_SLVERR);
        $display("t_reset done");
    endtask

    task automatic t_table_irq();
        for (int n = 0; n < 17; n++) begin
            wr(ADDR_VTAB + 12'(4 * n), {16'h0, 8'hC0 + 8'(n), 8'h10 + 8'(n)}, RESP_OKAY);
        end
        rc(ADDR_VTAB + 12'h008, 32'h0000C212, RESP_OKAY);
        wr(ADDR_MASK, 32'h0001FFFF, RESP_OKAY);
        run_en <= 1'b1;
        serve(IDX_RESET);
        chk({31'h0, irq}, 32'h1);
        rc(ADDR_STATUS, 32'h1, RESP_OKAY);
        wr(ADDR_STATUS, 32'h1, RESP_OKAY);
        wr(ADDR_MASK, 32'h0, RESP_OKAY);
        software_break_instruction <= 1'b1;
        @(posedge ref_clk);
        software_break_instruction <= 1'b0;
        serve(IDX_BREAK);
        chk({31'h0, irq}, 32'h0);
        rc(ADDR_STATUS, 32'h00010000, RESP_OKAY);
        wr(ADDR_MASK, 32'h00010000, RESP_OKAY);
        @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_STATUS, 32'h00010000, RESP_OKAY);
        @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        run_en <= 1'b0;
        $display("t_table_irq done");
    endtask

    task automatic t_prio();
        wr(ADDR_SRC_SET, 32'hF, RESP_OKAY);
        software_break_instruction <= 1'b1;
        pulse(17'h1FFFF);
        software_break_instruction <= 1'b0;
        rc(ADDR_PENDING, 32'h0001FFFE, RESP_OKAY);
        rc(ADDR_SRC_DISC, 32'hF, RESP_OKAY);
        rc(ADDR_SRC_DISC, 32'h0, RESP_OKAY);
        run_en <= 1'b1;
        for (int i = 1; i <= 16; i++) serve(i[4:0]);
        run_en <= 1'b0;
        rc(ADDR_STATUS, 32'h0001FFFE, RESP_OKAY);
        wr(ADDR_STATUS, 32'h0001FFFF, RESP_OKAY);
        $display("t_prio done");
    endtask

    task automatic t_shared();
        wr(ADDR_SRC_SET, 32'h0, RESP_OKAY);
        pulse(17'h180C0);
        wr(ADDR_PENDING, 32'h0001FFFF, RESP_OKAY);
        rc(ADDR_PENDING, 32'h0, RESP_OKAY);
        rc(ADDR_SRC_DISC, 32'h0, RESP_OKAY);
        wr(ADDR_SRC_SET, 32'h6, RESP_OKAY);
        pulse(17'h180C0);
        rc(ADDR_PENDING, 32'h00008080, RESP_OKAY);
        rc(ADDR_SRC_DISC, 32'h6, RESP_OKAY);
        run_en <= 1'b1;
        serve(IDX_WAKE);
        serve(IDX_CONV);
        run_en <= 1'b0;
        $display("t_shared done");
    endtask

    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        sys_rst = 1'b1;
        run_en = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        software_break_instruction = 1'b0;
        req_pins = 17'h00000;
        err_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_table_irq();
        t_prio();
        t_shared();
        tally_and_finish();
    end
endmodule
